// ---- logic/bstap_pkg.sv ----
/*
 Constants, opcode table and state types of the boundary-scan test port.
 Assumes one 20 MHz system clock that samples the slower test clock pins.
*/
// Contract
// - instruction register is exactly 10 bits between data in and data out
// - sample/preload captures pin values and preloads an output pattern, pins untouched
// - external test drives pins from the scan register and captures inputs
// - bypass places one flip-flop between data in and data out
// - identification places the 32-bit code register in the serial path
// - code fields: version 4, part 16, maker 11, then one constant bit
// - code bit zero is always one, first bit out
// - fields are listed most significant bit leftmost
// - enhanced variant only: user-code selects 32-bit user register
// - non-enhanced variant only: user-signature selects 16-bit signature register
// - user-signature instruction puts the signature into the serial path on the non-enhanced variant; enhanced decodes it as bypass
// - boundary scan chain length is 480 cells for this size
// - programming instructions are accepted through the test port
package bstap_pkg;
   // ----------------------------------------
   // register lengths
   // ----------------------------------------
   localparam int IR_LEN = 10;
   localparam int BSR_LEN = 480;
   localparam int ID_LEN = 32;
   localparam int UCODE_LEN = 32;
   localparam int USIG_LEN = 16;
   localparam int ISP_LEN = 32;
   localparam int BYP_LEN = 1;
   localparam int SH_LEN = BSR_LEN;
   localparam int SH_IDX_W = 9;
   // ----------------------------------------
   // identification field positions
   // ----------------------------------------
   localparam int ID_VER_POS = 28;
   localparam int ID_PART_POS = 12;
   localparam int ID_MFR_POS = 1;
   localparam logic ID_LSB = 1'b1;
   // arbitrary neutral identity values
   localparam logic [3:0] ID_VERSION = 4'h5;
   localparam logic [15:0] ID_PART = 16'hA5C3;
   localparam logic [10:0] ID_MAKER = 11'h2AB;
   // ----------------------------------------
   // opcode table and capture pattern
   // ----------------------------------------
   localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
   localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h055;
   localparam logic [IR_LEN-1:0] OP_IDCODE = 10'h059;
   localparam logic [IR_LEN-1:0] OP_USERCODE = 10'h079;
   localparam logic [IR_LEN-1:0] OP_USERSIG = 10'h065;
   localparam logic [IR_LEN-1:0] OP_ISP_ENTER = 10'h2CC;
   localparam logic [IR_LEN-1:0] OP_ISP_DATA = 10'h2F0;
   localparam logic [IR_LEN-1:0] OP_ISP_EXIT = 10'h201;
   localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;
   localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;
   // ----------------------------------------
   // buffering
   // ----------------------------------------
   localparam int FIFO_WIDTH = 32;
   localparam int FIFO_DEPTH = 8;
   localparam int MCLK_HZ = 20000000;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } bstap_state_type;

   typedef enum logic [3:0] {
      INS_BYPASS, INS_SAMPLE, INS_EXTEST, INS_IDCODE, INS_USERCODE,
      INS_USERSIG, INS_ISP_ENTER, INS_ISP_DATA, INS_ISP_EXIT
   } bstap_instr_type;
endpackage

// ---- logic/bstap_stream_if.sv ----
/*
 Valid/ready word stream between the port logic and its buffer.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/10ps
interface bstap_stream_if;
   logic valid;
   logic ready;
   logic [31:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ---- logic/bstap_fifo.sv ----
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
module bstap_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   bstap_stream_if.snk wr,
   bstap_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp, rp, next_wp, next_rp;
   logic [AW:0] cnt, next_cnt;
   logic do_wr, do_rd;

   // ----------------------------------------
   // pointer arithmetic
   // ----------------------------------------
   // full and empty come from the count, so they are never guessed
   always_comb begin
      do_wr = wr.valid && (cnt != (AW+1)'(DEPTH));
      do_rd = rd.ready && (cnt != '0);
      next_wp = do_wr ? AW'(wp + 1'b1) : wp;
      next_rp = do_rd ? AW'(rp + 1'b1) : rp;
      next_cnt = cnt;
      if (do_wr && !do_rd) begin
         next_cnt = (AW+1)'(cnt + 1'b1);
      end else if (do_rd && !do_wr) begin
         next_cnt = (AW+1)'(cnt - 1'b1);
      end
   end

   // pointer registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
         cnt <= next_cnt;
      end
   end

   // storage, no reset needed on data
   always_ff @(posedge i_mclk) begin
      if (do_wr) begin
         mem[wp] <= wr.data;
      end
   end

   assign wr.ready = (cnt != (AW+1)'(DEPTH));
   assign rd.valid = (cnt != '0);
   assign rd.data = mem[rp];
endmodule

// ---- logic/bstap_top.sv ----
/*
 Boundary-scan test access port: state machine, instruction register,
 bypass, identification, user code or signature, boundary chain and a
 programming data path into a FIFO.
 Assumes the test clock and its pins are asynchronous to i_mclk and at
 least four system clocks per test clock phase.
*/
`timescale 1ns/10ps
module bstap_top #(
   parameter bit ENHANCED = 1'b1
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tck,
   input wire logic i_tms,
   input wire logic i_tdi,
   output logic o_tdo,
   output logic o_tdo_oe,
   input wire logic [bstap_pkg::BSR_LEN-1:0] i_pin_in,
   output logic [bstap_pkg::BSR_LEN-1:0] o_pin_drive,
   output logic o_extest,
   input wire logic [bstap_pkg::UCODE_LEN-1:0] i_user_code,
   input wire logic [bstap_pkg::USIG_LEN-1:0] i_user_signature,
   output logic o_isp_mode,
   output logic o_isp_valid,
   output logic [bstap_pkg::ISP_LEN-1:0] o_isp_data,
   input wire logic i_isp_ready
);
   import bstap_pkg::*;

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic [2:0] tck_sync;
   logic [1:0] tms_sync, tdi_sync;
   logic [BSR_LEN-1:0] pin_s1, pin_s2;
   logic tck_rise, tck_fall, tms, tdi;
   bstap_state_type state, next_state;
   bstap_instr_type instr, next_instr;
   logic [IR_LEN-1:0] ir_sh, next_ir_sh;
   logic [SH_LEN-1:0] sh, next_sh;
   logic [SH_IDX_W-1:0] dr_len;
   logic [BSR_LEN-1:0] next_pin_drive;
   logic next_extest, next_isp_mode, next_tdo, next_tdo_oe;
   logic fill_valid, next_fill_valid;
   logic [ISP_LEN-1:0] fill_data, next_fill_data;
   logic next_isp_valid;
   logic [ISP_LEN-1:0] next_isp_data;
   logic [ID_LEN-1:0] idcode;

   bstap_stream_if fill_if ();
   bstap_stream_if drain_if ();

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // opcode table; anything unknown or absent on this variant is bypass
   function automatic bstap_instr_type decode(input logic [IR_LEN-1:0] op);
      bstap_instr_type r;
      case (op)
         OP_EXTEST: r = INS_EXTEST;
         OP_SAMPLE: r = INS_SAMPLE;
         OP_IDCODE: r = INS_IDCODE;
         OP_USERCODE: r = ENHANCED ? INS_USERCODE : INS_BYPASS;
         OP_USERSIG: r = ENHANCED ? INS_BYPASS : INS_USERSIG;
         OP_ISP_ENTER: r = INS_ISP_ENTER;
         OP_ISP_DATA: r = INS_ISP_DATA;
         OP_ISP_EXIT: r = INS_ISP_EXIT;
         default: r = INS_BYPASS;
      endcase
      return r;
   endfunction

   // standard state graph of the test access port
   function automatic bstap_state_type tap_next(input bstap_state_type s, input logic m);
      bstap_state_type r;
      case (s)
         TLR: r = m ? TLR : RTI;
         RTI: r = m ? SEL_DR : RTI;
         SEL_DR: r = m ? SEL_IR : CAP_DR;
         CAP_DR: r = m ? EX1_DR : SH_DR;
         SH_DR: r = m ? EX1_DR : SH_DR;
         EX1_DR: r = m ? UPD_DR : PAU_DR;
         PAU_DR: r = m ? EX2_DR : PAU_DR;
         EX2_DR: r = m ? UPD_DR : SH_DR;
         UPD_DR: r = m ? SEL_DR : RTI;
         SEL_IR: r = m ? TLR : CAP_IR;
         CAP_IR: r = m ? EX1_IR : SH_IR;
         SH_IR: r = m ? EX1_IR : SH_IR;
         EX1_IR: r = m ? UPD_IR : PAU_IR;
         PAU_IR: r = m ? EX2_IR : PAU_IR;
         EX2_IR: r = m ? UPD_IR : SH_IR;
         UPD_IR: r = m ? SEL_DR : RTI;
         default: r = TLR;
      endcase
      return r;
   endfunction

   // length of the data register that the instruction selects
   function automatic logic [SH_IDX_W-1:0] len_of(input bstap_instr_type ins);
      logic [SH_IDX_W-1:0] r;
      case (ins)
         INS_SAMPLE, INS_EXTEST: r = SH_IDX_W'(BSR_LEN);
         INS_IDCODE: r = SH_IDX_W'(ID_LEN);
         INS_USERCODE: r = SH_IDX_W'(UCODE_LEN);
         INS_USERSIG: r = SH_IDX_W'(USIG_LEN);
         INS_ISP_DATA: r = SH_IDX_W'(ISP_LEN);
         default: r = SH_IDX_W'(BYP_LEN);
      endcase
      return r;
   endfunction

   // msb-first field order, constant one in bit zero
   assign idcode = {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
   assign dr_len = len_of(instr);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // edges are found only after two flops, so a slow test clock is safe
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tck_sync <= '0;
         tms_sync <= 2'h3;
         tdi_sync <= 2'h3;
         pin_s1 <= '0;
         pin_s2 <= '0;
      end else begin
         tck_sync <= {tck_sync[1:0], i_tck};
         tms_sync <= {tms_sync[0], i_tms};
         tdi_sync <= {tdi_sync[0], i_tdi};
         pin_s1 <= i_pin_in;
         pin_s2 <= pin_s1;
      end
   end

   assign tck_rise = tck_sync[1] && !tck_sync[2];
   assign tck_fall = !tck_sync[1] && tck_sync[2];
   assign tms = tms_sync[1];
   assign tdi = tdi_sync[1];

   // ----------------------------------------
   // port state, scan paths and updates
   // ----------------------------------------
   // port work happens on the sampled test clock rising edge, output on fall; a taken word clears on any clock
   always_comb begin
      next_state = state;
      next_instr = instr;
      next_ir_sh = ir_sh;
      next_sh = sh;
      next_pin_drive = o_pin_drive;
      next_extest = o_extest;
      next_isp_mode = o_isp_mode;
      next_tdo = o_tdo;
      next_tdo_oe = o_tdo_oe;
      next_fill_valid = fill_valid;
      next_fill_data = fill_data;
      // a pending word leaves once the buffer takes it
      if (fill_valid && fill_if.ready) begin
         next_fill_valid = 1'b0;
      end
      if (tck_rise) begin
         next_state = tap_next(state, tms);
         case (state)
            TLR: begin
               next_instr = INS_IDCODE;
               next_extest = 1'b0;
               next_isp_mode = 1'b0;
            end
            CAP_IR: begin
               next_ir_sh = IR_CAPTURE;
            end
            SH_IR: begin
               next_ir_sh = {tdi, ir_sh[IR_LEN-1:1]};
            end
            UPD_IR: begin
               next_instr = decode(ir_sh);
               next_extest = (decode(ir_sh) == INS_EXTEST);
               if (decode(ir_sh) == INS_ISP_ENTER) begin
                  next_isp_mode = 1'b1;
               end else if (decode(ir_sh) == INS_ISP_EXIT) begin
                  next_isp_mode = 1'b0;
               end
            end
            CAP_DR: begin
               next_sh = '0;
               case (instr)
                  INS_SAMPLE, INS_EXTEST: next_sh = pin_s2;
                  INS_IDCODE: next_sh[ID_LEN-1:0] = idcode;
                  INS_USERCODE: next_sh[UCODE_LEN-1:0] = i_user_code;
                  INS_USERSIG: next_sh[USIG_LEN-1:0] = i_user_signature;
                  // master polls this bit before sending the next word
                  INS_ISP_DATA: next_sh[0] = !fill_valid;
                  default: next_sh[0] = 1'b0;
               endcase
            end
            SH_DR: begin
               next_sh = {1'b0, sh[SH_LEN-1:1]};
               next_sh[SH_IDX_W'(dr_len - 1'b1)] = tdi;
            end
            UPD_DR: begin
               // preload changes pins only once external test takes over
               if (instr == INS_SAMPLE || instr == INS_EXTEST) begin
                  next_pin_drive = sh;
               end
               // a word arriving while one is pending is dropped
               if (instr == INS_ISP_DATA && o_isp_mode && !fill_valid) begin
                  next_fill_valid = 1'b1;
                  next_fill_data = sh[ISP_LEN-1:0];
               end
            end
            default: begin
               next_sh = sh;
            end
         endcase
      end
      // output changes half a test clock after the shift edge
      if (tck_fall) begin
         next_tdo_oe = (state == SH_DR) || (state == SH_IR);
         next_tdo = (state == SH_IR) ? ir_sh[0] : sh[0];
      end
   end

   // port registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state <= TLR;
         instr <= INS_IDCODE;
         ir_sh <= IR_CAPTURE;
         sh <= '0;
         o_pin_drive <= '0;
         o_extest <= 1'b0;
         o_isp_mode <= 1'b0;
         o_tdo <= 1'b0;
         o_tdo_oe <= 1'b0;
         fill_valid <= 1'b0;
         fill_data <= '0;
      end else begin
         state <= next_state;
         instr <= next_instr;
         ir_sh <= next_ir_sh;
         sh <= next_sh;
         o_pin_drive <= next_pin_drive;
         o_extest <= next_extest;
         o_isp_mode <= next_isp_mode;
         o_tdo <= next_tdo;
         o_tdo_oe <= next_tdo_oe;
         fill_valid <= next_fill_valid;
         fill_data <= next_fill_data;
      end
   end

   // ----------------------------------------
   // programming data buffer
   // ----------------------------------------
   assign fill_if.valid = fill_valid;
   assign fill_if.data = fill_data;

   bstap_fifo #(
      .WIDTH(FIFO_WIDTH),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .wr(fill_if.snk),
      .rd(drain_if.src)
   );

   // ----------------------------------------
   // registered output stage
   // ----------------------------------------
   // costs one system clock of latency but keeps the outputs straight from flops
   assign drain_if.ready = !o_isp_valid || i_isp_ready;

   always_comb begin
      next_isp_valid = o_isp_valid;
      next_isp_data = o_isp_data;
      if (drain_if.ready) begin
         next_isp_valid = drain_if.valid;
         if (drain_if.valid) begin
            next_isp_data = drain_if.data;
         end
      end
   end

   // output stage registers
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_isp_valid <= 1'b0;
         o_isp_data <= '0;
      end else begin
         o_isp_valid <= next_isp_valid;
         o_isp_data <= next_isp_data;
      end
   end
endmodule

// ---- dv/bstap_sva.sv ----
/*
 Checker for the test port, bound to bstap_top; it sees the top ports only.
 Assumes each test clock phase lasts at least four system clocks.
*/
`timescale 1ns/10ps
module bstap_sva (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_tck,
   input wire logic o_tdo,
   input wire logic o_tdo_oe,
   input wire logic [bstap_pkg::BSR_LEN-1:0] o_pin_drive,
   input wire logic o_extest,
   input wire logic o_isp_mode,
   input wire logic o_isp_valid,
   input wire logic [bstap_pkg::ISP_LEN-1:0] o_isp_data,
   input wire logic i_isp_ready
);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // one domain, so clock and reset are stated once
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);

   // serial output moves only after a test clock fall, two sync stages late
   a_tdo_on_fall: assert property ($changed(o_tdo) |-> !$past(i_tck, 2))
      else $error("tdo moved in the high phase");
   a_oe_on_fall: assert property ($changed(o_tdo_oe) |-> !$past(i_tck, 2))
      else $error("tdo enable moved in the high phase");
   // update registers and mode flags change only on a test clock rise
   a_drive_on_rise: assert property ($changed(o_pin_drive) |-> $past(i_tck, 2))
      else $error("pin drive changed off a rise");
   a_extest_on_rise: assert property ($changed(o_extest) |-> $past(i_tck, 2))
      else $error("extest flag changed off a rise");
   a_mode_on_rise: assert property ($changed(o_isp_mode) |-> $past(i_tck, 2))
      else $error("programming mode changed off a rise");
   // a word stands until it is taken
   a_word_holds: assert property (o_isp_valid && !i_isp_ready |=> o_isp_valid && $stable(o_isp_data))
      else $error("programming word dropped or changed early");
   a_word_leaves: assert property ($fell(o_isp_valid) |-> $past(i_isp_ready))
      else $error("programming word left untaken");
   a_word_in_mode: assert property ($rose(o_isp_valid) |-> $past(o_isp_mode, 2))
      else $error("programming word outside programming mode");
endmodule

bind bstap_top bstap_sva sva_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_tck(i_tck), .o_tdo(o_tdo),
   .o_tdo_oe(o_tdo_oe), .o_pin_drive(o_pin_drive), .o_extest(o_extest),
   .o_isp_mode(o_isp_mode), .o_isp_valid(o_isp_valid), .o_isp_data(o_isp_data),
   .i_isp_ready(i_isp_ready));

// ---- dv/bstap_master.sv ----
/*
 Test port master model: drives test clock, mode select and data in.
 Assumes tasks are called from one bench process; tck rests low between frames.
*/
`timescale 1ns/10ps
module bstap_master (
   output logic o_tck,
   output logic o_tms,
   output logic o_tdi,
   input wire logic i_tdo
);
   // idle levels at time zero
   initial begin
      o_tck = 1'b0;
      o_tms = 1'b1;
      o_tdi = 1'b0;
   end

   // one 400 ns cycle; a stage costs its pulse plus cycles times this
   task automatic step(input logic ms, input logic di, output logic got);
      o_tms = ms;
      o_tdi = di;
      #200 o_tck = 1'b1;
      #100 got = i_tdo; // read mid high phase, well clear of the next fall
      #100 o_tck = 1'b0;
   endtask

   // state walk, mode select bits taken lsb first
   task automatic walk(input logic [7:0] seq, input int n);
      logic got;
      for (int i = 0; i < n; i++) step(seq[i], ~o_tdi, got);
   endtask

   // shift lsb first, leave on the last bit, then update and idle
   task automatic shift(input logic [511:0] din, input int n, output logic [511:0] dout);
      dout = '0;
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
      walk(8'h01, 2);
   endtask

   // instruction load from idle, returns the captured pattern
   task automatic ir(input logic [9:0] op, output logic [9:0] cap);
      logic [511:0] d;
      walk(8'h03, 4);
      shift({502'b0, op}, 10, d);
      cap = d[9:0];
   endtask

   // data register pass from idle
   task automatic dr(input logic [511:0] din, input int n, output logic [511:0] dout);
      walk(8'h01, 3);
      shift(din, n, dout);
   endtask
endmodule

// ---- dv/bstap_top_bench.sv ----
/*
 Self-checking bench of the test port with a master model on the link.
 Assumes dut_u built with ENHANCED at its default of one; a second copy
 without the enhanced variant answers the user-signature pass.
*/
`timescale 1ns/10ps
module bstap_top_bench;
   import bstap_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic isp_ready = 1'b0;
   logic sel_sig = 1'b0;
   logic sig_tdo, sig_oe;
   logic tck, tms, tdi, tdo_pin, o_tdo, o_tdo_oe, o_extest, o_isp_mode, o_isp_valid;
   logic [BSR_LEN-1:0] pin_in = '0;
   logic [BSR_LEN-1:0] o_pin_drive;
   logic [UCODE_LEN-1:0] ucode = '0;
   logic [USIG_LEN-1:0] usig = '0;
   logic [ISP_LEN-1:0] o_isp_data;
   logic [511:0] din, dout;
   logic [9:0] cap, op;
   logic [9:0] ops[6];
   logic [31:0] words[$];
   int n_errors = 0;
   int checks_done = 0;
   int len;

   // ----------------------------------------
   // clock, pin and instances
   // ----------------------------------------
   always #25 i_mclk = ~i_mclk;
   // pull-up holds an undriven tdo high; sel_sig picks which copy answers
   assign tdo_pin = sel_sig ? (sig_oe ? sig_tdo : 1'b1) : (o_tdo_oe ? o_tdo : 1'b1);
   bstap_master m_u (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(tdo_pin));
   bstap_top dut_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .i_pin_in(pin_in), .o_pin_drive(o_pin_drive),
      .o_extest(o_extest), .i_user_code(ucode), .i_user_signature(usig),
      .o_isp_mode(o_isp_mode), .o_isp_valid(o_isp_valid), .o_isp_data(o_isp_data),
      .i_isp_ready(isp_ready));
   // same link walk, so both copies stay in the same port state
   bstap_top #(
      .ENHANCED(1'b0)
   ) dut_sig_u (.i_mclk(i_mclk), .i_rst(i_rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .o_tdo(sig_tdo), .o_tdo_oe(sig_oe), .i_pin_in(pin_in), .o_pin_drive(),
      .o_extest(), .i_user_code(ucode), .i_user_signature(usig),
      .o_isp_mode(), .o_isp_valid(), .o_isp_data(), .i_isp_ready(isp_ready));

   // comparison and counting
   task automatic chk(input string what, input logic [511:0] exp, input logic [511:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // expected data register length and capture; user signature is bypass here
   function automatic int dr_len(input logic [9:0] o);
      return (o == OP_IDCODE || o == OP_USERCODE) ? 32 : 1;
   endfunction
   function automatic logic [31:0] dr_cap(input logic [9:0] o);
      if (o == OP_IDCODE) return {ID_VERSION, ID_PART, ID_MAKER, ID_LSB};
      return (o == OP_USERCODE) ? ucode : 32'h0;
   endfunction
   function automatic logic [511:0] rnd512();
      logic [511:0] r;
      for (int i = 0; i < 16; i++) r[i*32+:32] = $urandom;
      return r;
   endfunction

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(48));
      repeat (16) @(posedge i_mclk);
      @(negedge i_mclk) i_rst = 1'b0;
      repeat (4) @(negedge i_mclk);
      ucode = $urandom;
      usig = 16'($urandom);
      m_u.walk(8'h00, 1);
      // identification straight after reset, over-shifted to show its length
      din = rnd512();
      m_u.dr(din, 64, dout);
      chk("idcode", {din[31:0], ID_VERSION, ID_PART, ID_MAKER, ID_LSB}, dout);
      chk("first bit out", 1'b1, dout[0]);
      chk("tdo released", 1'b0, o_tdo_oe);
      $display("idcode test done");
      // path selection, unknown opcodes fall back to bypass
      ops = '{OP_IDCODE, OP_USERCODE, OP_USERSIG, OP_BYPASS, 10'h3FE, 10'(10'h100 | ($urandom % 256))};
      foreach (ops[k]) begin
         op = ops[k];
         m_u.ir(op, cap);
         chk("ir capture", IR_CAPTURE, cap);
         len = dr_len(op);
         din = rnd512();
         m_u.dr(din, len + 32, dout);
         chk("dr path", ({480'b0, din[31:0]} << len) | dr_cap(op), dout);
      end
      // non-enhanced copy: signature selected, user code falls back to bypass
      sel_sig = 1'b1;
      m_u.ir(OP_USERSIG, cap);
      din = rnd512();
      m_u.dr(din, 48, dout);
      chk("user signature", {din[31:0], usig}, dout);
      m_u.ir(OP_USERCODE, cap);
      m_u.dr(din, 33, dout);
      chk("user code absent", {din[31:0], 1'b0}, dout);
      sel_sig = 1'b0;
      $display("instruction table test done");
      // snapshot and preload, full chain plus tail
      pin_in = 480'(rnd512());
      m_u.ir(OP_SAMPLE, cap);
      din = rnd512();
      m_u.dr(din, 512, dout);
      chk("sample capture", pin_in, dout[479:0]);
      chk("chain tail", din[31:0], dout[511:480]);
      chk("preload", din[511:32], o_pin_drive);
      chk("extest idle", 1'b0, o_extest);
      // external test drives the preload, then a new pattern
      pin_in = 480'(rnd512());
      m_u.ir(OP_EXTEST, cap);
      chk("extest on", 1'b1, o_extest);
      chk("extest drive", din[511:32], o_pin_drive);
      din = rnd512();
      m_u.dr(din, 480, dout);
      chk("extest capture", pin_in, dout[479:0]);
      chk("extest update", din[479:0], o_pin_drive);
      m_u.walk(8'h1F, 6);
      chk("extest cleared", 1'b0, o_extest);
      $display("boundary test done");
      // programming words: fill until refused while downstream stalls
      m_u.ir(OP_ISP_ENTER, cap);
      chk("isp mode on", 1'b1, o_isp_mode);
      m_u.ir(OP_ISP_DATA, cap);
      for (int i = 0; i < 11; i++) begin
         din = rnd512();
         m_u.dr(din, 32, dout);
         chk("word slot free", i < 10, dout[0]);
         if (i < 10) words.push_back(din[31:0]);
      end
      // drain with random stalls; a word is taken at the rise after ready is set
      for (int i = 0; i < 400 && words.size() > 0; i++) begin
         @(negedge i_mclk) isp_ready = 1'($urandom % 2);
         if (o_isp_valid === 1'b1 && isp_ready) chk("isp word", words.pop_front(), o_isp_data);
      end
      chk("words drained", 0, words.size());
      repeat (8) @(negedge i_mclk);
      chk("refused word absent", 1'b0, o_isp_valid);
      m_u.ir(OP_ISP_EXIT, cap);
      chk("isp mode off", 1'b0, o_isp_mode);
      $display("programming test done");
      summarize();
   end
endmodule
